// File: hdl/brc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module brc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  brc_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  always_comb begin
    push = f.in_valid && f.in_ready;
    pop = f.out_valid && f.out_ready;
    next_wp = push ? ((wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp = pop ? ((rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= f.in_data;
    end
  end
  assign f.in_ready = (cnt != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt != '0);
  assign f.out_data = mem[rp];
endmodule
`default_nettype wire

// File: hdl/brc_top.sv
// Functional notes
// - Option 0x28: phase loop on, NRZI framing, internal source zero selected.
// - Option 0x36: phase loop on, Manchester framing, external clock selected.
// - Receive divisor 0x01 selects times-one mode only when external clock is selected: external clock used directly for rx ticks.
// - Divisors are eight bits wide; largest accepted value is 255.
// - N-times external mode: bit rate is external rate over divisor plus one.
// - NRZI: invert line for zero, hold for one, at cell start.
// - Manchester: mid-cell fall for one, mid-cell rise for zero.
`timescale 1ns/100ps
`default_nettype none
`include "brc_regs.svh"
module brc_top #(
  parameter int DIV_W = 8,
  parameter int FIFO_DEPTH = `BRC_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] rx_clock_option_setting,
  input wire brc_pkg::brc_div_t rx_rate_divisor,
  input wire brc_pkg::brc_div_t tx_rx_rate_divisor,
  input wire logic internal_source_zero,
  input wire logic ext_clk,
  input wire logic rx_line,
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_line,
  output logic rx_tick,
  output logic tx_tick,
  output logic pll_enable,
  output var brc_pkg::brc_frame_e frame_mode,
  output logic ext_selected,
  output logic x1_mode,
  output logic rx_bit,
  output logic rx_bit_valid
);
  import brc_pkg::*;
  // Three-stage sampling of off-domain pins
  logic [2:0] ext_s, rxl_s;
  logic ext_lvl, rxl_lvl, ext_prev;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_s <= '0;
      // Line idles high; no false level change after reset
      rxl_s <= '1;
      ext_lvl <= 1'b0;
      rxl_lvl <= 1'b1;
      ext_prev <= 1'b0;
    end else begin
      ext_s <= {ext_s[1:0], ext_clk};
      rxl_s <= {rxl_s[1:0], rx_line};
      if (ext_s[1] == ext_s[2]) begin
        ext_lvl <= ext_s[2];
      end
      if (rxl_s[1] == rxl_s[2]) begin
        rxl_lvl <= rxl_s[2];
      end
      ext_prev <= ext_lvl;
    end
  end
  logic ext_rise;
  assign ext_rise = ext_lvl && !ext_prev;
  // Option decode
  logic next_pll, next_ext, next_x1;
  brc_frame_e next_frame;
  always_comb begin
    next_pll = 1'b0;
    next_ext = 1'b0;
    next_frame = BRC_FRAME_NRZ;
    if (rx_clock_option_setting == `BRC_OPT_NRZI_INT) begin
      next_pll = 1'b1;
      next_frame = BRC_FRAME_NRZI;
      next_ext = 1'b0;
    end else if (rx_clock_option_setting == `BRC_OPT_MAN_EXT) begin
      next_pll = 1'b1;
      next_frame = BRC_FRAME_MAN;
      next_ext = 1'b1;
    end
    next_x1 = next_ext && (rx_rate_divisor == `BRC_DIV_X1);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pll_enable <= 1'b0;
      ext_selected <= 1'b0;
      frame_mode <= BRC_FRAME_NRZ;
      x1_mode <= 1'b0;
    end else begin
      pll_enable <= next_pll;
      ext_selected <= next_ext;
      frame_mode <= next_frame;
      x1_mode <= next_x1;
    end
  end
  // Source strobe and divisor counters
  logic src_en, int_prev;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_prev <= 1'b0;
    end else begin
      int_prev <= internal_source_zero;
    end
  end
  assign src_en = ext_selected ? ext_rise : (internal_source_zero && !int_prev);
  logic [DIV_W-1:0] rx_cnt, tx_cnt, next_rx_cnt, next_tx_cnt;
  logic next_rx_tick, next_tx_tick;
  always_comb begin
    next_rx_cnt = rx_cnt;
    next_tx_cnt = tx_cnt;
    next_rx_tick = 1'b0;
    next_tx_tick = 1'b0;
    if (src_en) begin
      if (x1_mode) begin
        next_rx_tick = 1'b1;
      end else if (rx_cnt == '0) begin
        next_rx_cnt = DIV_W'(rx_rate_divisor);
        next_rx_tick = 1'b1;
      end else begin
        next_rx_cnt = rx_cnt - 1'b1;
      end
      if (tx_cnt == '0) begin
        next_tx_cnt = DIV_W'(tx_rx_rate_divisor);
        next_tx_tick = 1'b1;
      end else begin
        next_tx_cnt = tx_cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_cnt <= '0;
      tx_cnt <= '0;
      rx_tick <= 1'b0;
      tx_tick <= 1'b0;
    end else begin
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
      rx_tick <= next_rx_tick;
      tx_tick <= next_tx_tick;
    end
  end
  // Transmit bit buffer
  brc_fifo_if #(.WIDTH(1)) fq ();
  brc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .f(fq.fifo)
  );
  logic half, next_half, cur_bit, next_cur_bit, next_tx_line;
  always_comb begin
    fq.in_data = tx_bit;
    fq.in_valid = tx_valid;
    fq.out_ready = tx_tick && !half;
    next_half = half;
    next_cur_bit = cur_bit;
    next_tx_line = tx_line;
    if (tx_tick) begin
      if (!half) begin
        // Idle cells send ones
        next_cur_bit = fq.out_valid ? fq.out_data : 1'b1;
        unique case (frame_mode)
          BRC_FRAME_NRZI: next_tx_line = next_cur_bit ? tx_line : !tx_line;
          BRC_FRAME_MAN: next_tx_line = next_cur_bit;
          default: next_tx_line = next_cur_bit;
        endcase
        next_half = (frame_mode == BRC_FRAME_MAN);
      end else begin
        next_tx_line = !cur_bit;
        next_half = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      half <= 1'b0;
      cur_bit <= 1'b1;
      tx_line <= 1'b1;
      tx_ready <= 1'b0;
    end else begin
      half <= next_half;
      cur_bit <= next_cur_bit;
      tx_line <= next_tx_line;
      tx_ready <= fq.in_ready;
    end
  end
  // Receive decode, sampled on rx ticks
  logic rx_prev, rx_half, next_rx_prev, next_rx_half, next_rx_bit, next_rx_bv;
  always_comb begin
    next_rx_prev = rx_prev;
    next_rx_half = rx_half;
    next_rx_bit = rx_bit;
    next_rx_bv = 1'b0;
    if (rx_tick) begin
      next_rx_prev = rxl_lvl;
      unique case (frame_mode)
        BRC_FRAME_NRZI: begin
          next_rx_bit = (rxl_lvl == rx_prev);
          next_rx_bv = 1'b1;
        end
        BRC_FRAME_MAN: begin
          next_rx_half = !rx_half;
          if (rx_half) begin
            next_rx_bit = rx_prev && !rxl_lvl;
            next_rx_bv = 1'b1;
          end
        end
        default: begin
          next_rx_bit = rxl_lvl;
          next_rx_bv = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_prev <= 1'b1;
      rx_half <= 1'b0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else begin
      rx_prev <= next_rx_prev;
      rx_half <= next_rx_half;
      rx_bit <= next_rx_bit;
      rx_bit_valid <= next_rx_bv;
    end
  end
endmodule
`default_nettype wire

// File: pkg/brc_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface brc_fifo_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (input in_data, input in_valid, output in_ready,
    output out_data, output out_valid, input out_ready);
  modport user (output in_data, output in_valid, input in_ready,
    input out_data, input out_valid, output out_ready);
endinterface
`default_nettype wire

// File: pkg/brc_pkg.sv
package brc_pkg;
  typedef enum logic [1:0] {
    BRC_FRAME_NRZ = 2'b00,
    BRC_FRAME_NRZI = 2'b01,
    BRC_FRAME_MAN = 2'b11
  } brc_frame_e;
  typedef logic [7:0] brc_div_t;
endpackage

// File: pkg/brc_regs.svh
`ifndef BRC_REGS_SVH
`define BRC_REGS_SVH
`define BRC_OPT_NRZI_INT 8'h28
`define BRC_OPT_MAN_EXT 8'h36
`define BRC_DIV_X1 8'h01
`define BRC_DIV_RST 8'h01
`define BRC_OPT_RST 8'h00
`define BRC_FIFO_DEPTH 16
`endif

// File: sim/brc_remote.sv
`timescale 1ns/100ps
`default_nettype none
module brc_remote (
  output logic ext_clk,
  output logic rx_line
);
  initial begin
    ext_clk = 1'b0;
    rx_line = 1'b1;
  end
  // Clock stands low between bursts
  task burst(input int n);
    repeat (n) begin
      #43 ext_clk = 1'b1;
      rx_line = ~rx_line;
      #40 ext_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: sim/brc_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module brc_top_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] rx_clock_option_setting,
  input wire brc_pkg::brc_div_t rx_rate_divisor,
  input wire logic tx_line,
  input wire logic tx_tick,
  input wire logic rx_tick,
  input wire logic pll_enable,
  input wire brc_pkg::brc_frame_e frame_mode,
  input wire logic ext_selected,
  input wire logic x1_mode
);
  import brc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence man_cfg;
    rx_clock_option_setting == 8'h36;
  endsequence
  sequence nrzi_cfg;
    rx_clock_option_setting == 8'h28;
  endsequence
  chk_opt_nrzi: assert property (
    nrzi_cfg |=> pll_enable && frame_mode == BRC_FRAME_NRZI && !ext_selected)
    else $error("nrzi setup");
  chk_opt_man: assert property (
    man_cfg |=> pll_enable && frame_mode == BRC_FRAME_MAN && ext_selected)
    else $error("manchester setup");
  chk_opt_plain: assert property (
    !(rx_clock_option_setting inside {8'h28, 8'h36}) |=> !pll_enable && !ext_selected)
    else $error("plain setup");
  chk_x1_sel: assert property (
    1'b1 |=> x1_mode == ($past(rx_rate_divisor) == 8'h01
      && $past(rx_clock_option_setting) == 8'h36))
    else $error("x1 select");
  chk_x1_ext: assert property (x1_mode |-> ext_selected)
    else $error("x1 without ext");
  chk_tx_pulse: assert property (tx_tick |=> !tx_tick)
    else $error("tx tick width");
  chk_rx_pulse: assert property (rx_tick |=> !rx_tick)
    else $error("rx tick width");
  chk_line_hold: assert property (
    $changed(tx_line) && $past(rst_n) |-> tx_tick || $past(tx_tick))
    else $error("line moved off tick");
endmodule
bind brc_top brc_top_assertions chk (.core_clk, .rst_n, .rx_clock_option_setting,
  .rx_rate_divisor, .tx_line, .tx_tick, .rx_tick, .pll_enable, .frame_mode,
  .ext_selected, .x1_mode);
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import brc_pkg::*;
  logic core_clk = 0, rst_n = 0, src = 0, tb = 0, tv = 0, tt_d = 0;
  logic [7:0] opt = 8'h00;
  brc_div_t rdiv = 8'h01, tdiv = 8'h01;
  wire logic ext, rxl;
  logic txr, txl, rt, tt, pll, exs, x1, rb, rbv;
  brc_frame_e fm;
  int fails = 0, n_checks = 0, nrt = 0, ntt = 0, nrv = 0, a, b, c;
  logic txq[$];
  logic [23:0] rows [5] = '{24'h282114, 24'h36011F, 24'h36051E, 24'h000100, 24'hFF0100};
  brc_remote r (.ext_clk(ext), .rx_line(rxl));
  brc_top uut (.core_clk, .rst_n, .rx_clock_option_setting(opt), .rx_rate_divisor(rdiv),
    .tx_rx_rate_divisor(tdiv), .internal_source_zero(src), .ext_clk(ext), .rx_line(rxl),
    .tx_bit(tb), .tx_valid(tv), .tx_ready(txr), .tx_line(txl), .rx_tick(rt), .tx_tick(tt),
    .pll_enable(pll), .frame_mode(fm), .ext_selected(exs), .x1_mode(x1), .rx_bit(rb),
    .rx_bit_valid(rbv));
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    nrt <= nrt + int'(rt);
    ntt <= ntt + int'(tt);
    nrv <= nrv + int'(rbv);
    tt_d <= tt;
    if (tt_d) txq.push_back(txl);
  end
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task edges(input int n);
    cyc(1);
    repeat (n) begin
      src <= 1'b1;
      cyc(2);
      src <= 1'b0;
      cyc(2);
    end
  endtask
  // Fresh reset so divisor counters start from zero
  task setup(input logic [7:0] o, input brc_div_t d);
    cyc(1);
    opt <= o;
    tdiv <= d;
    rdiv <= d;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
  endtask
  task count(input logic [7:0] o, input brc_div_t d, input int n);
    setup(o, d);
    a = ntt;
    b = nrt;
    c = nrv;
    txq.delete();
    if (o == 8'h36) r.burst(n);
    else edges(n);
    cyc(12);
  endtask
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    #1 chk({rb, rbv, txl, pll, fm, exs, x1}, 8'h20);
    chk({5'b0, txr, rt, tt}, 8'h00);
    $display("reset done");
    cyc(2);
    #1 chk(txr, 8'h01);
    foreach (rows[i]) begin
      cyc(1);
      opt <= rows[i][23:16];
      rdiv <= rows[i][15:8];
      cyc(2);
      #1 chk({3'b0, pll, fm, exs, x1}, rows[i][7:0]);
    end
    $display("modes done");
    count(8'h00, 8'h03, 40);
    chk(8'(ntt - a), 8'h0A);
    chk(8'(nrt - b), 8'h0A);
    chk(8'(nrv - c), 8'h0A);
    chk(rb, 8'h01);
    count(8'h00, 8'hFF, 257);
    chk(8'(ntt - a), 8'h02);
    count(8'h36, 8'h03, 16);
    chk(8'(nrt - b), 8'h04);
    count(8'h36, 8'h01, 16);
    chk(8'(nrt - b), 8'h10);
    chk(8'(nrv - c), 8'h08);
    chk(rb, 8'h00);
    chk({4'h0, txq[0], txq[1], txq[2], txq[3]}, 8'h0A);
    $display("rates done");
    setup(8'h28, 8'h00);
    tv <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tb <= i == 1 || i == 2;
      cyc(1);
    end
    tv <= 1'b0;
    txq.delete();
    edges(4);
    cyc(4);
    chk({4'h0, txq[0], txq[1], txq[2], txq[3]}, 8'h01);
    $display("nrzi done");
    setup(8'h00, 8'h00);
    tb <= 1'b1;
    tv <= 1'b1;
    cyc(20);
    tv <= 1'b0;
    cyc(2);
    #1 chk(txr, 8'h00);
    edges(20);
    cyc(4);
    #1 chk(txr, 8'h01);
    $display("fifo done");
    results();
  end
  initial begin
    #40000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
